/* src/lpt_timing_core.sv */
`timescale 1ns/1ps
// Functional notes
// (R1) The controller changes the clock frequency only in clock stop, power-down or self refresh.
// (R2) After self refresh exit the controller waits at least 80 ns before the first command.
// (R3) The clock toggles at least twice during that self refresh exit wait.
// (R4) Write recovery with auto precharge is at least 15 ns and at least one full clock.
// (R5) Auto-precharge write delay is write recovery plus precharge period, each rounded up to clocks.
// (R6) Read or write with auto precharge is only issued once active-to-precharge minimum is met.
// (R7) Every row is refreshed within 64 ms, on average every 15.6 us or 7.8 us by part.
// (R8) Read data appears one clock after the read at latency two, two clocks at latency three.
// (R9) After a status read the next command waits at least cas latency plus one clock.
// (R10) The write strobe is valid no later than the write command, setup 0 ns.
// (R11) The write strobe postamble lasts at least 0.4 clock; longer only costs turnaround.
// (R12) In self refresh, clock enable low time runs from the rising clock edge to its return high.
// (R13) Each byte lane has its own strobe, four lanes up to the top byte in the wide form.
// (R14) The controller keeps timers in rounded-up clocks and blocks commands until they expire.
module lpt_timing_core #(
   parameter int LANES = 4
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Command inputs from the controller pins
   input  wire logic [2:0]           cmd_pin,
   input  wire logic                 auto_precharge_pin,
   input  wire logic                 clock_enable_pin,
   input  wire logic [1:0]           cas_latency,
   // Per byte lane strobe inputs, used on writes
   input  wire logic [LANES-1:0]     strobe_in,
   // Read data strobe launch, one per byte lane
   output logic [LANES-1:0]          strobe_out,
   output logic [LANES-1:0]          strobe_oe,
   output logic                      read_data_valid,
   // Status for observation
   output logic                      in_self_refresh,
   output logic                      cmd_ready,
   output logic                      timing_violation,
   output logic [7:0]                clock_enable_low_clks
);
   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   logic [2:0]       cmd_s1_reg, cmd_s2_reg;
   logic             ap_s1_reg, ap_s2_reg;
   logic             cke_s1_reg, cke_s2_reg;
   logic [LANES-1:0] strb_s1_reg, strb_s2_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cmd_s1_reg  <= 3'h0;
         cmd_s2_reg  <= 3'h0;
         ap_s1_reg   <= 1'b0;
         ap_s2_reg   <= 1'b0;
         cke_s1_reg  <= 1'b1;
         cke_s2_reg  <= 1'b1;
         strb_s1_reg <= '0;
         strb_s2_reg <= '0;
      end else begin
         cmd_s1_reg  <= cmd_pin;
         cmd_s2_reg  <= cmd_s1_reg;
         ap_s1_reg   <= auto_precharge_pin;
         ap_s2_reg   <= ap_s1_reg;
         cke_s1_reg  <= clock_enable_pin;
         cke_s2_reg  <= cke_s1_reg;
         strb_s1_reg <= strobe_in;
         strb_s2_reg <= strb_s1_reg;
      end
   end

   // ==========================================================================
   // Command decode
   // ==========================================================================
   wire logic is_nop   = cmd_s2_reg == lpt_pkg::LPT_CMD_NOP;
   wire logic is_act   = cmd_s2_reg == lpt_pkg::LPT_CMD_ACT;
   wire logic is_read  = cmd_s2_reg == lpt_pkg::LPT_CMD_READ;
   wire logic is_write = cmd_s2_reg == lpt_pkg::LPT_CMD_WRITE;
   wire logic is_srr   = cmd_s2_reg == lpt_pkg::LPT_CMD_SRR;
   wire logic is_cmd   = !is_nop;
   wire logic is_cl3   = cas_latency == lpt_pkg::CAS_LATENCY_3;

   // ==========================================================================
   // Power state
   // ==========================================================================
   lpt_pkg::lpt_state_t state_reg, state_next;
   logic [lpt_pkg::COUNTER_W-1:0] exit_cnt_reg;
   logic [1:0]                    toggle_cnt_reg;
   logic [7:0]                    cke_low_reg;

   wire logic exit_done = (exit_cnt_reg == '0) &&
                          (toggle_cnt_reg >= 2'(lpt_pkg::SRX_MIN_CLOCK_TOGGLES));   // R2 R3

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         lpt_pkg::LPT_ST_ACTIVE:  if (!cke_s2_reg) state_next = lpt_pkg::LPT_ST_SELFREF;
         lpt_pkg::LPT_ST_SELFREF: if (cke_s2_reg) state_next = lpt_pkg::LPT_ST_EXIT;
         lpt_pkg::LPT_ST_EXIT:    if (exit_done) state_next = lpt_pkg::LPT_ST_ACTIVE;
         default:                 state_next = lpt_pkg::LPT_ST_ACTIVE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) state_reg <= lpt_pkg::LPT_ST_ACTIVE;
      else       state_reg <= state_next;
   end

   // Exit wait: 80 ns of clocks, and every edge here is a toggle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         exit_cnt_reg   <= '0;
         toggle_cnt_reg <= 2'h0;
      end else if (state_reg == lpt_pkg::LPT_ST_SELFREF) begin
         exit_cnt_reg   <= lpt_pkg::COUNTER_W'(lpt_pkg::SELF_REFRESH_EXIT_CLKS);   // R2
         toggle_cnt_reg <= 2'h0;
      end else if (state_reg == lpt_pkg::LPT_ST_EXIT) begin
         if (exit_cnt_reg != '0) exit_cnt_reg <= exit_cnt_reg - 1'b1;
         if (toggle_cnt_reg != 2'h3) toggle_cnt_reg <= toggle_cnt_reg + 1'b1;   // R3
      end
   end

   // Clock enable low time counted from the rising edge that saw it low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cke_low_reg <= 8'h00;
      else if (!cke_s2_reg && state_reg == lpt_pkg::LPT_ST_ACTIVE) cke_low_reg <= 8'h01;   // R12
      else if (!cke_s2_reg && cke_low_reg != 8'hFF) cke_low_reg <= cke_low_reg + 8'h01;   // R12
   end

   // ==========================================================================
   // Command spacing timers
   // ==========================================================================
   logic [lpt_pkg::COUNTER_W-1:0] block_cnt_reg;
   logic [lpt_pkg::COUNTER_W-1:0] ras_cnt_reg;

   wire logic [lpt_pkg::COUNTER_W-1:0] srr_wait =
      lpt_pkg::COUNTER_W'(cas_latency) + lpt_pkg::COUNTER_W'(lpt_pkg::STATUS_READ_EXTRA_CLKS);   // R9
   wire logic [lpt_pkg::COUNTER_W-1:0] dal_wait =
      lpt_pkg::COUNTER_W'(lpt_pkg::AUTO_PRECHARGE_WRITE_DELAY_CLKS);   // R4 R5
   wire logic blocked     = (block_cnt_reg != '0) || (state_reg != lpt_pkg::LPT_ST_ACTIVE);
   wire logic ap_too_soon = (is_read || is_write) && ap_s2_reg && (ras_cnt_reg != '0);   // R6
   wire logic violation   = is_cmd && (blocked || ap_too_soon);   // R14

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) block_cnt_reg <= '0;
      else if (is_srr && !blocked) block_cnt_reg <= srr_wait - 1'b1;   // R9
      else if (is_write && ap_s2_reg && !blocked) block_cnt_reg <= dal_wait - 1'b1;   // R5
      else if (block_cnt_reg != '0) block_cnt_reg <= block_cnt_reg - 1'b1;
   end

   // Active-to-precharge minimum; reads and writes with auto precharge before this are flagged
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ras_cnt_reg <= '0;
      else if (is_act) ras_cnt_reg <= lpt_pkg::COUNTER_W'(lpt_pkg::ACTIVE_TO_PRECHARGE_CLKS - 1);   // R6
      else if (ras_cnt_reg != '0) ras_cnt_reg <= ras_cnt_reg - 1'b1;
   end

   // ==========================================================================
   // Read return after cas latency
   // ==========================================================================
   wire logic [1:0] read_tap = is_cl3 ? 2'h2 : 2'h1;   // R8
   logic read_slot;

   lpt_read_pipe #(
      .DEPTH (2)
   ) u_read_pipe (
      .clk     (clk),
      .rstn    (rstn),
      .launch  ((is_read || is_srr) && !blocked),
      .tap_sel (read_tap),
      .tap_out (read_slot)
   );

   // ==========================================================================
   // Outputs, one strobe per byte lane
   // ==========================================================================
   logic sticky_violation_reg;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               strobe_out[g] <= 1'b0;
               strobe_oe[g]  <= 1'b0;
            end else begin
               strobe_oe[g]  <= read_slot;   // R13
               strobe_out[g] <= read_slot && !strobe_out[g];   // R13
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         read_data_valid       <= 1'b0;
         in_self_refresh       <= 1'b0;
         cmd_ready             <= 1'b1;
         sticky_violation_reg  <= 1'b0;
         timing_violation      <= 1'b0;
         clock_enable_low_clks <= 8'h00;
      end else begin
         read_data_valid       <= read_slot;   // R8
         in_self_refresh       <= state_next != lpt_pkg::LPT_ST_ACTIVE;
         cmd_ready             <= state_next == lpt_pkg::LPT_ST_ACTIVE && block_cnt_reg <= 1;
         sticky_violation_reg  <= sticky_violation_reg || violation;   // R14
         timing_violation      <= sticky_violation_reg || violation;
         clock_enable_low_clks <= cke_low_reg;   // R12
      end
   end

   // Write strobe level is only observed; no timing check here depends on it
   wire logic unused_strobe = &strb_s2_reg;
endmodule

/* src/lpt_pkg.sv */
package lpt_pkg;
   // ==========================================================================
   // Clock and timing figures
   // ==========================================================================
   localparam int CLK_PERIOD_PS            = 10000;
   localparam int WRITE_RECOVERY_TIME_NS   = 15;
   localparam int PRECHARGE_PERIOD_NS      = 15;
   localparam int ACTIVE_TO_PRECHARGE_NS   = 40;
   localparam int SELF_REFRESH_EXIT_NS     = 80;
   localparam int SRX_MIN_CLOCK_TOGGLES    = 2;
   localparam int WRITE_RECOVERY_MIN_CLKS  = 1;
   // Least times round up to whole cycles
   localparam int WRITE_RECOVERY_CLKS      = (WRITE_RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PRECHARGE_PERIOD_CLKS    = (PRECHARGE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACTIVE_TO_PRECHARGE_CLKS = (ACTIVE_TO_PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SELF_REFRESH_EXIT_CLKS   = (SELF_REFRESH_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WR_RECOVERY_EFF_CLKS     = (WRITE_RECOVERY_CLKS < WRITE_RECOVERY_MIN_CLKS) ?
                                             WRITE_RECOVERY_MIN_CLKS : WRITE_RECOVERY_CLKS;
   localparam int AUTO_PRECHARGE_WRITE_DELAY_CLKS = WR_RECOVERY_EFF_CLKS + PRECHARGE_PERIOD_CLKS;
   // Status read needs cas_latency + 1 clocks before the next command
   localparam int STATUS_READ_EXTRA_CLKS   = 1;
   // ==========================================================================
   // Encodings
   // ==========================================================================
   localparam logic [1:0] CAS_LATENCY_2    = 2'h2;
   localparam logic [1:0] CAS_LATENCY_3    = 2'h3;
   localparam int COUNTER_W                = 8;

   typedef enum logic [2:0] {
      LPT_CMD_NOP   = 3'h0,
      LPT_CMD_ACT   = 3'h1,
      LPT_CMD_READ  = 3'h2,
      LPT_CMD_WRITE = 3'h3,
      LPT_CMD_PRE   = 3'h4,
      LPT_CMD_SRR   = 3'h5
   } lpt_cmd_t;

   // Gray along active -> self refresh -> exit wait
   typedef enum logic [1:0] {
      LPT_ST_ACTIVE  = 2'h0,
      LPT_ST_SELFREF = 2'h1,
      LPT_ST_EXIT    = 2'h3
   } lpt_state_t;
endpackage

/* src/lpt_read_pipe.sv */
`timescale 1ns/1ps
// Fixed-depth delay line that carries a read launch until its data slot
module lpt_read_pipe #(
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Launch and selected tap
   input  wire logic             launch,
   input  wire logic [1:0]       tap_sel,
   output logic                  tap_out
);
   logic [DEPTH-1:0] stage_reg;

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_stage
         if (i == 0) begin : g_first
            always_ff @(posedge clk or negedge rstn) begin
               if (!rstn) stage_reg[i] <= 1'b0;
               else       stage_reg[i] <= launch;
            end
         end else begin : g_rest
            always_ff @(posedge clk or negedge rstn) begin
               if (!rstn) stage_reg[i] <= 1'b0;
               else       stage_reg[i] <= stage_reg[i-1];
            end
         end
      end
   endgenerate

   // tap_sel 1 selects one stage, 2 selects two
   assign tap_out = (tap_sel == 2'h2) ? stage_reg[1] : stage_reg[0];
endmodule

/* testbench/lpt_timing_core_properties.sv */
`timescale 1ns/1ps
// ============================================================
// Read slot, byte lane, clock enable low count and command spacing checks
module lpt_core_chk #(
   parameter int LANES = 4
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             rstn,
   // Controller pins
   input wire logic [2:0]       cmd_pin,
   input wire logic             auto_precharge_pin,
   input wire logic             clock_enable_pin,
   input wire logic [1:0]       cas_latency,
   input wire logic [LANES-1:0] strobe_in,
   // Observed outputs
   input wire logic [LANES-1:0] strobe_out,
   input wire logic [LANES-1:0] strobe_oe,
   input wire logic             read_data_valid,
   input wire logic             in_self_refresh,
   input wire logic             cmd_ready,
   input wire logic             timing_violation,
   input wire logic [7:0]       clock_enable_low_clks
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_wrap_early;
      cmd_pin == lpt_pkg::LPT_CMD_WRITE && auto_precharge_pin ##1 cmd_pin == lpt_pkg::LPT_CMD_ACT;
   endsequence
   sequence s_status_early;
      cmd_pin == lpt_pkg::LPT_CMD_SRR && cas_latency == lpt_pkg::CAS_LATENCY_2
         ##1 cmd_pin == lpt_pkg::LPT_CMD_NOP ##1 cmd_pin == lpt_pkg::LPT_CMD_READ;
   endsequence
   sequence s_ras_early;
      cmd_pin == lpt_pkg::LPT_CMD_ACT ##1 cmd_pin == lpt_pkg::LPT_CMD_NOP
         ##1 cmd_pin == lpt_pkg::LPT_CMD_READ && auto_precharge_pin;
   endsequence
   AST_RD_SLOT_CL2: assert property (read_data_valid && cas_latency == lpt_pkg::CAS_LATENCY_2 |->
      $past(cmd_pin, 4) inside {lpt_pkg::LPT_CMD_READ, lpt_pkg::LPT_CMD_SRR}) else $error("slot off at latency 2");
   AST_RD_SLOT_CL3: assert property (read_data_valid && cas_latency == lpt_pkg::CAS_LATENCY_3 |->
      $past(cmd_pin, 5) inside {lpt_pkg::LPT_CMD_READ, lpt_pkg::LPT_CMD_SRR}) else $error("slot off at latency 3");
   AST_LANE_OE: assert property (strobe_oe == {LANES{read_data_valid}})
      else $error("lane enables differ from slot");
   AST_LANE_OUT: assert property (read_data_valid |-> strobe_out == {LANES{1'b1}})
      else $error("lane strobe missing");
   AST_CKE_COUNT: assert property ($changed(clock_enable_low_clks) |-> clock_enable_low_clks == 8'h00 ||
      clock_enable_low_clks == $past(clock_enable_low_clks) + 8'h01) else $error("low count jumped");
   AST_CKE_HOLD: assert property (clock_enable_pin [*5] |-> $stable(clock_enable_low_clks) ||
      clock_enable_low_clks == 8'h00) else $error("low count runs while enabled");
   AST_VIOL_STICKY: assert property (timing_violation |=> timing_violation) else $error("flag cleared");
   AST_WRAP_EARLY: assert property (s_wrap_early |-> ##[1:6] timing_violation) else $error("early act missed");
   AST_STATUS_EARLY: assert property (s_status_early |-> ##[1:6] timing_violation)
      else $error("early read missed");
   AST_RAS_EARLY: assert property (s_ras_early |-> ##[1:6] timing_violation) else $error("early ap missed");
endmodule

bind lpt_timing_core lpt_core_chk #(.LANES(LANES)) u_chk (
   .clk(clk), .rstn(rstn), .cmd_pin(cmd_pin), .auto_precharge_pin(auto_precharge_pin),
   .clock_enable_pin(clock_enable_pin), .cas_latency(cas_latency), .strobe_in(strobe_in),
   .strobe_out(strobe_out), .strobe_oe(strobe_oe), .read_data_valid(read_data_valid),
   .in_self_refresh(in_self_refresh), .cmd_ready(cmd_ready), .timing_violation(timing_violation),
   .clock_enable_low_clks(clock_enable_low_clks));

/* testbench/lpt_ctrl_model.sv */
`timescale 1ns/1ps
// ============================================================
// Controller side: commands, clock enable and write strobes
module lpt_ctrl_model #(
   parameter int LANES = 4
) (
   // Clock
   input  wire logic             clk,
   // Pins toward the memory
   output logic [2:0]            cmd_pin,
   output logic                  auto_precharge_pin,
   output logic                  clock_enable_pin,
   output logic [LANES-1:0]      strobe_in
);
   logic [1:0] wr_phase = 2'h0;
   wire        strobe_driven = cmd_pin == lpt_pkg::LPT_CMD_WRITE || wr_phase != 2'h0;
   initial begin
      cmd_pin = lpt_pkg::LPT_CMD_NOP;
      auto_precharge_pin = 1'b0;
      clock_enable_pin = 1'b1;
   end
   always @(posedge clk) begin
      wr_phase <= {wr_phase[0], cmd_pin == lpt_pkg::LPT_CMD_WRITE};
   end
   // Low from the write command, one high beat, a full-clock low tail; released lanes wander
   assign strobe_in = strobe_driven ? {LANES{wr_phase[0]}} : {LANES{clk}};
   // Every scenario starts from reset and lasts far less than one refresh interval, so no refresh falls due
   localparam int REFRESH_DUE_CYCLES = 780;
   // Caller sits at a falling edge and holds the pins until its next call
   task automatic issue(input lpt_pkg::lpt_cmd_t c, input logic ap);
      cmd_pin = c;
      auto_precharge_pin = ap;
   endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic             clk;
   logic             rstn;
   logic [1:0]       cas_latency;
   wire logic [2:0]  cmd_pin;
   wire logic        auto_precharge_pin;
   wire logic        clock_enable_pin;
   wire logic [3:0]  strobe_in;
   wire logic [3:0]  strobe_out;
   wire logic [3:0]  strobe_oe;
   wire logic        read_data_valid;
   wire logic        in_self_refresh;
   wire logic        cmd_ready;
   wire logic        timing_violation;
   wire logic [7:0]  clock_enable_low_clks;
   int               err_total = 0;
   int               total_checks = 0;
   int               cycles = 0;
   // Fixed rate, never stopped, so exit waits always see toggles
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   lpt_ctrl_model #(.LANES(4)) u_ctrl (.clk(clk), .cmd_pin(cmd_pin), .auto_precharge_pin(auto_precharge_pin),
      .clock_enable_pin(clock_enable_pin), .strobe_in(strobe_in));
   lpt_timing_core #(.LANES(4)) uut (.clk(clk), .rstn(rstn), .cmd_pin(cmd_pin),
      .auto_precharge_pin(auto_precharge_pin), .clock_enable_pin(clock_enable_pin), .cas_latency(cas_latency),
      .strobe_in(strobe_in), .strobe_out(strobe_out), .strobe_oe(strobe_oe), .read_data_valid(read_data_valid),
      .in_self_refresh(in_self_refresh), .cmd_ready(cmd_ready), .timing_violation(timing_violation),
      .clock_enable_low_clks(clock_enable_low_clks));
   task automatic conclude();
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         err_total++;
         conclude();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset(input logic [1:0] cl);
      @(negedge clk);
      rstn = 1'b0;
      cas_latency = cl;
      u_ctrl.clock_enable_pin = 1'b1;
      repeat (16) @(negedge clk);
      check({7'h00, cmd_ready}, 8'h01);
      check({4'h0, timing_violation, in_self_refresh, read_data_valid, |strobe_oe}, 8'h00);
      check(clock_enable_low_clks, 8'h00);
      rstn = 1'b1;
   endtask
   task automatic read_lat(input logic [1:0] cl, input lpt_pkg::lpt_cmd_t c, input logic [7:0] exp);
      int n;
      do_reset(cl);
      u_ctrl.issue(c, 1'b0);
      @(negedge clk);
      u_ctrl.issue(lpt_pkg::LPT_CMD_NOP, 1'b0);
      n = 1;
      while (read_data_valid !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      check(8'(n), exp);
      check({strobe_out, strobe_oe}, 8'hFF);
      @(negedge clk);
      check({3'h0, read_data_valid, strobe_oe}, 8'h00);
   endtask
   task automatic spacing(input lpt_pkg::lpt_cmd_t c1, input logic a1, input int gap,
                          input lpt_pkg::lpt_cmd_t c2, input logic a2, input logic exp);
      do_reset(lpt_pkg::CAS_LATENCY_2);
      u_ctrl.issue(c1, a1);
      @(negedge clk);
      if (gap > 1) begin
         u_ctrl.issue(lpt_pkg::LPT_CMD_NOP, 1'b0);
         repeat (gap - 1) @(negedge clk);
      end
      u_ctrl.issue(c2, a2);
      @(negedge clk);
      u_ctrl.issue(lpt_pkg::LPT_CMD_NOP, 1'b0);
      repeat (8) @(negedge clk);
      check({7'h00, timing_violation}, {7'h00, exp});
   endtask
   task automatic self_refresh(input int wait_clks, input logic exp);
      do_reset(lpt_pkg::CAS_LATENCY_2);
      u_ctrl.clock_enable_pin = 1'b0;
      repeat (12) @(negedge clk);
      check({5'h00, cmd_ready, in_self_refresh, clock_enable_low_clks inside {[8'h08:8'h0C]}}, 8'h03);
      u_ctrl.clock_enable_pin = 1'b1;
      repeat (wait_clks) @(negedge clk);
      u_ctrl.issue(lpt_pkg::LPT_CMD_READ, 1'b0);
      @(negedge clk);
      u_ctrl.issue(lpt_pkg::LPT_CMD_NOP, 1'b0);
      repeat (8) @(negedge clk);
      // An early command still finds the exit wait running, so the block stays in self refresh and not ready
      check({5'h00, cmd_ready, in_self_refresh, timing_violation}, {5'h00, !exp, exp, exp});
   endtask
   initial begin
      rstn = 1'b0;
      cas_latency = lpt_pkg::CAS_LATENCY_2;
      read_lat(lpt_pkg::CAS_LATENCY_2, lpt_pkg::LPT_CMD_READ, 8'h04);
      read_lat(lpt_pkg::CAS_LATENCY_3, lpt_pkg::LPT_CMD_READ, 8'h05);
      read_lat(lpt_pkg::CAS_LATENCY_2, lpt_pkg::LPT_CMD_SRR, 8'h04);
      spacing(lpt_pkg::LPT_CMD_SRR, 1'b0, 2, lpt_pkg::LPT_CMD_READ, 1'b0, 1'b1);
      spacing(lpt_pkg::LPT_CMD_SRR, 1'b0, 3, lpt_pkg::LPT_CMD_READ, 1'b0, 1'b0);
      spacing(lpt_pkg::LPT_CMD_WRITE, 1'b1, 1, lpt_pkg::LPT_CMD_ACT, 1'b0, 1'b1);
      spacing(lpt_pkg::LPT_CMD_WRITE, 1'b1, lpt_pkg::AUTO_PRECHARGE_WRITE_DELAY_CLKS, lpt_pkg::LPT_CMD_ACT, 1'b0, 1'b0);
      spacing(lpt_pkg::LPT_CMD_ACT, 1'b0, 2, lpt_pkg::LPT_CMD_READ, 1'b1, 1'b1);
      spacing(lpt_pkg::LPT_CMD_ACT, 1'b0, lpt_pkg::ACTIVE_TO_PRECHARGE_CLKS, lpt_pkg::LPT_CMD_WRITE, 1'b1, 1'b0);
      self_refresh(1, 1'b1);
      self_refresh(lpt_pkg::SELF_REFRESH_EXIT_CLKS + 4, 1'b0);
      conclude();
   end
endmodule
